// *** logic/qitg_pkg.sv ***
`default_nettype none
package qitg_pkg;
	////////////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 20;
	localparam int SAMPLE_CYCLES = 2048;
	localparam int DERIV_MAX_STEPS = 256;
	localparam int DERIV_W = 8;
	localparam int POS_W = 31;
	localparam int PARAM_W = 32;
	localparam int FRAC_W = 16;
	localparam int ACC_W = POS_W + FRAC_W;
	localparam int BRK_W = 2 * PARAM_W + FRAC_W + 1;
	// Rates above 16383 counts per sample are folded back into range
	localparam logic [PARAM_W-1:0] RATE_MASK = 32'h3fff_ffff;
	localparam logic [POS_W-1:0] POS_RESET = 31'h0000_0000;
	// Quadrature states {a,b} in forward order
	localparam logic [1:0] QUAD_S0 = 2'h0;
	localparam logic [1:0] QUAD_S1 = 2'h2;
	localparam logic [1:0] QUAD_S2 = 2'h3;
	localparam logic [1:0] QUAD_S3 = 2'h1;
	localparam logic [2:0] ENC_IDLE = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic a;
		logic b;
		logic index;
	} enc_type;

	typedef struct packed {
		logic velocity_mode;
		logic reverse;
		logic [PARAM_W-1:0] accel;
		logic [PARAM_W-1:0] velocity;
		logic [PARAM_W-1:0] target;
	} traj_cmd_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_MOVE = 3'h2,
		ST_STOP = 3'h4
	} traj_state_type;

	// Forward successor of a quadrature state
	function automatic logic [1:0] quad_next(input logic [1:0] ab);
		unique case (ab)
			QUAD_S0: quad_next = QUAD_S1;
			QUAD_S1: quad_next = QUAD_S2;
			QUAD_S2: quad_next = QUAD_S3;
			QUAD_S3: quad_next = QUAD_S0;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** logic/quad_decoder.sv ***
`default_nettype none
module quad_decoder
	import qitg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Encoder pins
	input wire enc_type i_enc,
	// Decoded feedback
	output var enc_type o_enc_sync,
	output var logic signed [POS_W-1:0] o_position
);
	enc_type meta_q;
	enc_type sync_q;
	logic [1:0] prev_q;
	logic signed [POS_W-1:0] pos_q;
	wire logic [1:0] cur_ab;
	wire logic fwd;
	wire logic rev;

	assign cur_ab = {sync_q.a, sync_q.b};
	assign fwd = cur_ab == quad_next(prev_q);
	assign rev = prev_q == quad_next(cur_ab);
	assign o_enc_sync = sync_q;
	assign o_position = pos_q;

	// Two stages before decode; a double jump is a lost state and counts nothing
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= enc_type'(ENC_IDLE);
			sync_q <= enc_type'(ENC_IDLE);
			prev_q <= QUAD_S2;
			pos_q <= POS_RESET;
		end else begin
			meta_q <= i_enc;
			sync_q <= meta_q;
			prev_q <= cur_ab;
			if (fwd)
				pos_q <= pos_q + POS_W'(1);
			else if (rev)
				pos_q <= pos_q - POS_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_sync_count;
		@(posedge i_clk) disable iff (i_rst)
		$changed(pos_q) |-> $past(cur_ab) != $past(prev_q);
	endproperty
	a_sync_count: assert property (p_sync_count) else $error("count without synced edge");

	property p_forward;
		@(posedge i_clk) disable iff (i_rst)
		(prev_q == QUAD_S0 && cur_ab == QUAD_S1) |=> pos_q == $past(pos_q) + POS_W'(1);
	endproperty
	a_forward: assert property (p_forward) else $error("a leading b did not count up");
endmodule // quad_decoder
`default_nettype wire

// *** logic/sample_timer.sv ***
`default_nettype none
module sample_timer
	import qitg_pkg::*;
#(
	parameter int SAMPLE_LEN = SAMPLE_CYCLES
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Derivative interval minus one, in samples
	input wire logic [DERIV_W-1:0] i_deriv_div,
	// Ticks
	output var logic o_sample,
	output var logic o_deriv
);
	localparam int CW = $clog2(SAMPLE_LEN);
	logic [CW-1:0] cnt_q;
	logic [DERIV_W-1:0] dcnt_q;
	logic sample_q;
	logic deriv_q;
	wire logic wrap;
	wire logic dwrap;

	assign wrap = cnt_q == CW'(SAMPLE_LEN - 1);
	assign dwrap = dcnt_q >= i_deriv_div;
	assign o_sample = sample_q;
	assign o_deriv = deriv_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
			dcnt_q <= '0;
			sample_q <= 1'b0;
			deriv_q <= 1'b0;
		end else begin
			cnt_q <= wrap ? '0 : cnt_q + CW'(1);
			sample_q <= wrap;
			deriv_q <= wrap & dwrap;
			if (wrap)
				dcnt_q <= dwrap ? '0 : dcnt_q + DERIV_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] gap_q;
	logic seen_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end else begin
			gap_q <= sample_q ? 16'h0001 : gap_q + 16'h0001;
			seen_q <= seen_q | sample_q;
		end
	end

	property p_period;
		@(posedge i_clk) disable iff (i_rst)
		(sample_q && seen_q) |-> gap_q == 16'(SAMPLE_LEN);
	endproperty
	a_period: assert property (p_period) else $error("sample period wrong");

	property p_deriv;
		@(posedge i_clk) disable iff (i_rst)
		deriv_q |-> sample_q;
	endproperty
	a_deriv: assert property (p_deriv) else $error("derivative tick off sample grid");
endmodule // sample_timer
`default_nettype wire

// *** logic/quadrature_index_trajectory_generator.sv ***
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module quadrature_index_trajectory_generator
	import qitg_pkg::*;
#(
	parameter int SAMPLE_LEN = SAMPLE_CYCLES
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Encoder pins
	input wire enc_type i_enc,
	// Trajectory control
	input wire traj_cmd_type i_cmd,
	input wire logic i_load,
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic [DERIV_W-1:0] i_deriv_div,
	// Index capture and host alert
	input wire logic i_index_arm,
	input wire logic i_irq_clear,
	output logic o_host_irq,
	output logic o_all_low,
	output logic o_index_armed,
	output logic signed [POS_W-1:0] o_index_position,
	// Feedback and loop
	output logic signed [POS_W-1:0] o_position,
	output logic signed [POS_W-1:0] o_desired,
	output logic signed [PARAM_W-1:0] o_error,
	output logic [PARAM_W-1:0] o_velocity,
	output logic o_moving,
	output logic o_sample_tick,
	output logic o_deriv_tick
);
	////////////////////////////////////////////////////////////////////////////////
	enc_type enc_s;
	logic signed [POS_W-1:0] fb_pos;
	logic tick;
	logic dtick;

	quad_decoder u_dec (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_enc(i_enc),
		.o_enc_sync(enc_s),
		.o_position(fb_pos)
	);

	sample_timer #(
		.SAMPLE_LEN(SAMPLE_LEN)
	) u_tmr (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_deriv_div(i_deriv_div),
		.o_sample(tick),
		.o_deriv(dtick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Index capture
	logic all_low_prev_q;
	logic armed_q;
	logic irq_q;
	logic signed [POS_W-1:0] index_q;
	wire logic all_low;
	wire logic all_low_evt;
	wire logic capture;

	assign all_low = !enc_s.a && !enc_s.b && !enc_s.index;
	// Fires once per low window; a held-low index still retriggers every cycle of rotation
	assign all_low_evt = all_low && !all_low_prev_q;
	assign capture = all_low_evt && armed_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			all_low_prev_q <= 1'b1;
			armed_q <= 1'b0;
			irq_q <= 1'b0;
			index_q <= POS_RESET;
		end else begin
			all_low_prev_q <= all_low;
			// Single shot: software rearms after each capture, the arm wins a tie
			if (i_index_arm)
				armed_q <= 1'b1;
			else if (capture)
				armed_q <= 1'b0;
			if (capture)
				irq_q <= 1'b1;
			else if (i_irq_clear)
				irq_q <= 1'b0;
			if (capture)
				index_q <= fb_pos;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trajectory parameters and requests
	traj_cmd_type cmd_q;
	traj_cmd_type cmd_d;
	logic start_req_q;
	logic stop_req_q;

	always_comb begin
		cmd_d = i_cmd;
		cmd_d.accel = i_cmd.accel & RATE_MASK;
		cmd_d.velocity = i_cmd.velocity & RATE_MASK;
	end

	// Loads land at once but act on the next sample, so a move can be retargeted
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cmd_q <= '0;
			start_req_q <= 1'b0;
			stop_req_q <= 1'b0;
		end else begin
			if (i_load)
				cmd_q <= cmd_d;
			start_req_q <= i_start || (start_req_q && !tick);
			stop_req_q <= i_stop || (stop_req_q && !tick);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Profile arithmetic
	traj_state_type state_q;
	traj_state_type state_d;
	logic [PARAM_W-1:0] vel_q;
	logic [PARAM_W-1:0] vel_d;
	logic dir_q;
	logic dir_d;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic signed [PARAM_W-1:0] err_q;

	wire logic vmode;
	wire logic signed [POS_W-1:0] des;
	wire logic signed [POS_W-1:0] tgt;
	wire logic signed [POS_W:0] rem;
	wire logic [POS_W:0] rem_abs;
	wire logic want_dir;
	wire logic wrong_dir;
	wire logic [2*PARAM_W-1:0] v_sq;
	wire logic [BRK_W-1:0] dist_term;
	wire logic brake;
	wire logic want_zero;
	wire logic [PARAM_W-1:0] goal;
	wire logic [PARAM_W-1:0] vel_up;
	wire logic [PARAM_W-1:0] vel_dn;
	wire logic [PARAM_W-1:0] vel_next;
	wire logic step_dir;
	wire logic [ACC_W-1:0] step;
	wire logic [ACC_W-1:0] acc_step;
	wire logic arrive;
	wire logic signed [PARAM_W-1:0] err_d;

	assign vmode = cmd_q.velocity_mode;
	assign des = acc_q[ACC_W-1:FRAC_W];
	assign tgt = cmd_q.target[POS_W-1:0];
	assign rem = {tgt[POS_W-1], tgt} - {des[POS_W-1], des};
	assign rem_abs = rem[POS_W] ? $unsigned(-rem) : $unsigned(rem);

	// Reversal passes through zero speed before the new direction is taken
	assign want_dir = vmode ? cmd_q.reverse : rem[POS_W];
	assign wrong_dir = (vel_q != '0) && (dir_q != want_dir);

	// Brake once v*v reaches 2*a*distance; both sides carry 32 fraction bits
	assign v_sq = {32'h0000_0000, vel_q} * {32'h0000_0000, vel_q};
	assign dist_term = (BRK_W'(rem_abs) * BRK_W'(cmd_q.accel)) << (FRAC_W + 1);
	assign brake = BRK_W'(v_sq) >= dist_term;

	assign want_zero = (state_q == ST_STOP) || wrong_dir || (!vmode && brake);
	assign goal = want_zero ? '0 : cmd_q.velocity;

	assign vel_up = vel_q + cmd_q.accel;
	assign vel_dn = vel_q - cmd_q.accel;
	assign vel_next = (vel_q < goal) ? ((vel_up > goal) ? goal : vel_up) :
		(vel_q > goal) ? ((cmd_q.accel >= vel_q - goal) ? goal : vel_dn) : vel_q;

	assign step_dir = (vel_q == '0) ? want_dir : dir_q;
	assign step = {15'h0000, vel_next};
	// Whole fraction is kept, so sub-count speeds average out exactly
	assign acc_step = step_dir ? acc_q - step : acc_q + step;
	// Snap when the remaining distance fits inside one braking step
	assign arrive = !vmode && (state_q == ST_MOVE) && want_zero && !wrong_dir &&
		(rem_abs <= {16'h0000, vel_next[PARAM_W-1:FRAC_W]});

	assign err_d = PARAM_W'({des[POS_W-1], des} - {fb_pos[POS_W-1], fb_pos});

	always_comb begin
		state_d = state_q;
		vel_d = vel_q;
		dir_d = dir_q;
		acc_d = acc_q;
		if (tick) begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_req_q && !stop_req_q)
						state_d = ST_MOVE;
				end
				ST_MOVE: begin
					if (stop_req_q) begin
						state_d = ST_STOP;
					end else if (arrive) begin
						state_d = ST_IDLE;
						vel_d = '0;
						acc_d = {tgt, 16'h0000};
					end else begin
						vel_d = vel_next;
						dir_d = step_dir;
						acc_d = acc_step;
					end
				end
				ST_STOP: begin
					vel_d = vel_next;
					dir_d = step_dir;
					acc_d = acc_step;
					if (start_req_q && !stop_req_q)
						state_d = ST_MOVE;
					else if (vel_next == '0)
						state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			vel_q <= '0;
			dir_q <= 1'b0;
			acc_q <= '0;
			err_q <= '0;
		end else begin
			state_q <= state_d;
			vel_q <= vel_d;
			dir_q <= dir_d;
			acc_q <= acc_d;
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign o_host_irq = irq_q;
	assign o_all_low = all_low_evt;
	assign o_index_armed = armed_q;
	assign o_index_position = index_q;
	assign o_position = fb_pos;
	assign o_desired = des;
	assign o_error = err_q;
	assign o_velocity = vel_q;
	assign o_moving = state_q != ST_IDLE;
	assign o_sample_tick = tick;
	assign o_deriv_tick = dtick;

	////////////////////////////////////////////////////////////////////////////////
	property p_irq_after_cap;
		@(posedge i_clk) disable iff (i_rst)
		capture |=> o_host_irq;
	endproperty
	a_irq_after_cap: assert property (p_irq_after_cap) else $error("no irq after capture");

	property p_index_cap;
		@(posedge i_clk) disable iff (i_rst)
		capture |=> o_index_position == $past(fb_pos);
	endproperty
	a_index_cap: assert property (p_index_cap) else $error("index value wrong");

	property p_no_cap_unarmed;
		@(posedge i_clk) disable iff (i_rst)
		!armed_q |=> $stable(index_q);
	endproperty
	a_no_cap_unarmed: assert property (p_no_cap_unarmed) else $error("capture unarmed");

	property p_step_one;
		@(posedge i_clk) disable iff (i_rst)
		$changed(fb_pos) |-> (POS_W'(fb_pos - $past(fb_pos)) == POS_W'(1)) ||
			(POS_W'($past(fb_pos) - fb_pos) == POS_W'(1));
	endproperty
	a_step_one: assert property (p_step_one) else $error("position jumped");

	property p_vel_range;
		@(posedge i_clk) disable iff (i_rst)
		vel_q <= RATE_MASK;
	endproperty
	a_vel_range: assert property (p_vel_range) else $error("velocity out of range");

	property p_acc_add;
		@(posedge i_clk) disable iff (i_rst)
		(tick && state_q == ST_MOVE && !stop_req_q && !arrive && vel_q < goal &&
			vel_up <= goal) |=> vel_q == $past(vel_up);
	endproperty
	a_acc_add: assert property (p_acc_add) else $error("acceleration not added");

	property p_decel;
		@(posedge i_clk) disable iff (i_rst)
		(tick && state_q == ST_STOP && vel_q > cmd_q.accel && !start_req_q)
			|=> vel_q == $past(vel_dn);
	endproperty
	a_decel: assert property (p_decel) else $error("deceleration rate wrong");

	property p_hold_vel;
		@(posedge i_clk) disable iff (i_rst)
		(tick && state_q == ST_MOVE && vmode && !stop_req_q && vel_q == goal)
			|=> acc_q == $past(acc_step);
	endproperty
	a_hold_vel: assert property (p_hold_vel) else $error("velocity mode stalled");

	property p_arrive;
		@(posedge i_clk) disable iff (i_rst)
		(tick && arrive && !stop_req_q) |=> (des == $past(tgt)) && (vel_q == '0);
	endproperty
	a_arrive: assert property (p_arrive) else $error("stop not on target");

	property p_quiet;
		@(posedge i_clk) disable iff (i_rst)
		!tick |=> $stable(acc_q) && $stable(vel_q);
	endproperty
	a_quiet: assert property (p_quiet) else $error("profile moved off sample");

	property p_error;
		@(posedge i_clk) disable iff (i_rst)
		##1 o_error == $past(err_d);
	endproperty
	a_error: assert property (p_error) else $error("position error wrong");
endmodule // quadrature_index_trajectory_generator
`default_nettype wire

// *** test/enc_model.sv ***
`default_nettype none
module enc_model
	import qitg_pkg::*;
#(
	parameter int HOLD = 10
)
(
	// Clock
	input wire logic i_clk,
	// Motion requests
	input wire logic i_fwd,
	input wire logic i_rev,
	input wire logic i_home,
	// Encoder pins
	output var enc_type o_enc
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////////////
	// Own phase table, {a,b}, a leads b when stepping forward
	localparam logic [1:0] SEQ [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic [1:0] ph_q = 2'h0;
	int cnt_q = 0;

	// One step per HOLD clocks keeps every state above the 8-clock minimum
	always @(posedge i_clk) begin
		if (!(i_fwd || i_rev)) begin
			cnt_q <= 0;
		end else if (cnt_q == HOLD - 1) begin
			cnt_q <= 0;
			ph_q <= i_fwd ? ph_q + 2'h1 : ph_q - 2'h1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end

	// Home switch pulls index low whenever i_home is high, moving or at rest; otherwise pulled high
	assign o_enc = {SEQ[ph_q], ~i_home};
endmodule // enc_model
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
module testbench
	import qitg_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////////////
	localparam int SLEN = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	enc_type enc;
	traj_cmd_type cmd = '0;
	logic load = 1'b0;
	logic start = 1'b0;
	logic stop = 1'b0;
	logic [DERIV_W-1:0] div = 8'h01;
	logic arm = 1'b0;
	logic irq_clr = 1'b0;
	logic fwd = 1'b0;
	logic rev = 1'b0;
	logic home = 1'b0;
	logic host_irq, all_low, armed, moving, s_tick, d_tick, saw_low;
	logic signed [POS_W-1:0] index_pos, position, desired;
	logic signed [PARAM_W-1:0] error;
	logic [PARAM_W-1:0] velocity;
	int err_count = 0;
	int n_checks = 0;

	always #10 clk = ~clk;
	// Sampled mid-cycle: the pulse and the flops behind it move on the rising edge
	always @(negedge clk) if (all_low === 1'b1) saw_low = 1'b1;

	enc_model enc_u (.i_clk(clk), .i_fwd(fwd), .i_rev(rev), .i_home(home), .o_enc(enc));

	quadrature_index_trajectory_generator #(.SAMPLE_LEN(SLEN)) dut_u (
		.i_clk(clk), .i_rst(rst), .i_enc(enc), .i_cmd(cmd), .i_load(load),
		.i_start(start), .i_stop(stop), .i_deriv_div(div), .i_index_arm(arm),
		.i_irq_clear(irq_clr), .o_host_irq(host_irq), .o_all_low(all_low),
		.o_index_armed(armed), .o_index_position(index_pos), .o_position(position),
		.o_desired(desired), .o_error(error), .o_velocity(velocity), .o_moving(moving),
		.o_sample_tick(s_tick), .o_deriv_tick(d_tick));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic ncyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One-cycle request: 0 arms the index, 1 clears the alert, 2 stops the move
	task automatic pulse(input int sel);
		@(posedge clk);
		arm <= sel == 0;
		irq_clr <= sel == 1;
		stop <= sel == 2;
		@(posedge clk);
		arm <= 1'b0;
		irq_clr <= 1'b0;
		stop <= 1'b0;
	endtask

	// Returns one cycle after a sample tick, once that tick's updates are visible
	task automatic wait_tick();
		int k;
		for (k = 0; k < 100; k++) begin
			@(negedge clk);
			if (s_tick === 1'b1) break;
		end
		if (k == 100) begin
			err_count++;
			$display("BAD sample_tick expected 1 seen 0");
			summarize();
		end
		@(negedge clk);
	endtask

	task automatic run_steps(input logic back);
		@(posedge clk);
		fwd <= !back;
		rev <= back;
		repeat (80) @(posedge clk);
		fwd <= 1'b0;
		rev <= 1'b0;
		ncyc(10);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check("position", 32'(position), 32'h0000_0000);
		check("desired", 32'(desired), 32'h0000_0000);
		check("host_irq", 32'(host_irq), 32'h0000_0000);
		check("moving", 32'(moving), 32'h0000_0000);
		$display("done reset");
	endtask

	task automatic t_ticks();
		int i;
		int ns;
		int nd;
		int first;
		ns = 0;
		nd = 0;
		first = 0;
		wait_tick();
		for (i = 1; i <= 4 * SLEN; i++) begin
			@(negedge clk);
			if (s_tick === 1'b1 && ns++ == 0) first = i;
			if (d_tick === 1'b1) nd++;
		end
		check("tick_gap", 32'(first), 32'(SLEN - 1));
		check("tick_count", 32'(ns), 32'h0000_0004);
		check("deriv_count", 32'(nd), 32'h0000_0002);
		@(posedge clk);
		div <= 8'h03;
		nd = 0;
		wait_tick();
		for (i = 1; i <= 8 * SLEN; i++) begin
			@(negedge clk);
			if (d_tick === 1'b1) nd++;
		end
		check("deriv_count_4", 32'(nd), 32'h0000_0002);
		$display("done ticks");
	endtask

	task automatic t_encoder_index();
		run_steps(1'b0);
		check("position_fwd", 32'(position), 32'h0000_0008);
		saw_low = 1'b0;
		@(posedge clk);
		home <= 1'b1;
		ncyc(12);
		check("all_low", 32'(saw_low), 32'h0000_0001);
		check("irq_unarmed", 32'(host_irq), 32'h0000_0000);
		@(posedge clk);
		home <= 1'b0;
		pulse(0);
		ncyc(4);
		check("armed", 32'(armed), 32'h0000_0001);
		@(posedge clk);
		home <= 1'b1;
		ncyc(10);
		check("host_irq", 32'(host_irq), 32'h0000_0001);
		check("index_pos", 32'(index_pos), 32'h0000_0008);
		check("disarmed", 32'(armed), 32'h0000_0000);
		@(posedge clk);
		home <= 1'b0;
		pulse(1);
		ncyc(2);
		check("irq_cleared", 32'(host_irq), 32'h0000_0000);
		run_steps(1'b1);
		check("position_rev", 32'(position), 32'h0000_0000);
		$display("done encoder_index");
	endtask

	task automatic t_velocity();
		int k;
		logic [31:0] exp;
		logic [31:0] prev;
		@(posedge clk);
		cmd <= '{velocity_mode: 1'b1, reverse: 1'b0, accel: 32'h0000_8000,
			velocity: 32'h0002_0000, target: 32'h0000_0000};
		load <= 1'b1;
		start <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		start <= 1'b0;
		wait_tick();
		for (k = 1; k <= 6; k++) begin
			wait_tick();
			exp = (k * 32'h0000_8000 > 32'h0002_0000) ? 32'h0002_0000 : k * 32'h0000_8000;
			check("velocity_ramp", velocity, exp);
		end
		prev = 32'(desired);
		wait_tick();
		ncyc(2);
		check("desired_step", 32'(desired) - prev, 32'h0000_0002);
		check("error", error, 32'(desired) - 32'(position));
		pulse(2);
		prev = velocity;
		for (k = 0; k < 10; k++) begin
			wait_tick();
			if (velocity !== prev) check("decel_step", prev - velocity, 32'h0000_8000);
			prev = velocity;
		end
		check("stopped", 32'(moving), 32'h0000_0000);
		check("stop_vel", velocity, 32'h0000_0000);
		$display("done velocity");
	endtask

	task automatic t_position();
		int k;
		logic [31:0] base;
		logic [31:0] vmax;
		base = 32'(desired);
		vmax = '0;
		@(posedge clk);
		cmd <= '{velocity_mode: 1'b0, reverse: 1'b0, accel: 32'h0001_0000,
			velocity: 32'h0004_0000, target: base + 32'd60};
		load <= 1'b1;
		start <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		start <= 1'b0;
		repeat (3) wait_tick();
		@(posedge clk);
		cmd.target <= base + 32'd40;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		for (k = 0; k < 60 && moving === 1'b1; k++) begin
			wait_tick();
			if (velocity > vmax) vmax = velocity;
		end
		check("vmax", vmax, 32'h0004_0000);
		check("final_pos", 32'(desired), base + 32'd40);
		check("idle", 32'(moving), 32'h0000_0000);
		$display("done position");
	endtask

	task automatic t_reverse();
		logic [31:0] prev;
		@(posedge clk);
		cmd <= '{velocity_mode: 1'b1, reverse: 1'b1, accel: 32'h0001_0000,
			velocity: 32'h0001_0000, target: 32'h0000_0000};
		load <= 1'b1;
		start <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		start <= 1'b0;
		repeat (2) wait_tick();
		check("rev_velocity", velocity, 32'h0001_0000);
		prev = 32'(desired);
		wait_tick();
		check("rev_step", 32'(desired) - prev, 32'hffff_ffff);
		pulse(2);
		repeat (3) wait_tick();
		check("rev_stopped", 32'(moving), 32'h0000_0000);
		check("rev_stop_vel", velocity, 32'h0000_0000);
		$display("done reverse");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		ncyc(2);
		t_reset();
		t_ticks();
		t_encoder_index();
		t_velocity();
		t_position();
		t_reverse();
		summarize();
	end
endmodule // testbench
`default_nettype wire
